// ===== rtl/bridge_hdr_pkg.sv
// constants for the middle part of the bridge configuration header
package bridge_hdr_pkg;
  // ------------------------------------------------------------
  // dword offsets
  // ------------------------------------------------------------
  localparam logic [7:0] class_dword_offset = 8'h08;
  localparam logic [7:0] cache_dword_offset = 8'h0c;
  localparam logic [7:0] bus_dword_offset = 8'h18;
  // ------------------------------------------------------------
  // field positions (low bit of each byte lane)
  // ------------------------------------------------------------
  localparam int base_class_lsb = 24;
  localparam int cache_line_lsb = 0;
  localparam int latency_lsb = 8;
  localparam int header_type_lsb = 16;
  localparam int upstream_bus_lsb = 0;
  localparam int downstream_bus_lsb = 8;
  localparam int highest_bus_lsb = 16;
  // ------------------------------------------------------------
  // reset and constant values
  // ------------------------------------------------------------
  localparam logic [7:0] base_class_value = 8'h06;
  localparam logic [7:0] header_type_value = 8'h01;
  localparam logic [7:0] cache_line_reset = 8'h00;
  localparam logic [7:0] latency_reset = 8'h00;
  localparam logic [7:0] bus_number_reset = 8'h00;
  localparam logic [7:0] max_line_words = 8'h10;
  // ------------------------------------------------------------
  // configuration commands and forwarding decisions
  // ------------------------------------------------------------
  localparam logic [3:0] cmd_cfg_read = 4'ha;
  localparam logic [3:0] cmd_cfg_write = 4'hb;
  typedef enum logic [1:0] {
    fwd_none = 2'b00,
    fwd_type1 = 2'b01,
    fwd_type0 = 2'b10,
    fwd_special = 2'b11
  } fwd_type;
endpackage : bridge_hdr_pkg

// ===== rtl/latency_if.sv
// signals between the header and the primary master latency timer
interface latency_if;
  logic [7:0] count;
  logic frame_start;
  logic master_busy;
  logic gnt_removed;
  logic mwi_cycle;
  logic data_done;
  logic expired;
  logic release_bus;
  modport hdr(output count, frame_start, master_busy, gnt_removed, mwi_cycle, data_done,
    input expired, release_bus);
  modport timer(input count, frame_start, master_busy, gnt_removed, mwi_cycle, data_done,
    output expired, release_bus);
endinterface : latency_if

// ===== rtl/master_latency_timer.sv
// primary master latency timer, counting clocks from frame assertion
module master_latency_timer (
  input wire logic clk,       // primary clock
  input wire logic rst_n,     // synchronous reset
  latency_if.timer lt         // timer side
);
  logic [7:0] elapsed_reg;
  logic expired_reg;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      elapsed_reg <= 8'h00;
    end else if (lt.frame_start) begin
      elapsed_reg <= 8'h01;
    end else if (lt.master_busy && elapsed_reg != 8'hff) begin
      elapsed_reg <= elapsed_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expired_reg <= 1'b0;
    end else if (lt.frame_start) begin
      expired_reg <= (lt.count <= 8'h01);
    end else if (lt.master_busy) begin
      expired_reg <= expired_reg || (elapsed_reg + 8'h01 >= lt.count);
    end else begin
      expired_reg <= 1'b0;
    end
  end

  assign lt.expired = expired_reg;
  // zero count: give up after first data phase once grant is gone, not for mwi
  assign lt.release_bus = lt.master_busy && lt.gnt_removed && !lt.mwi_cycle &&
    ((lt.count == 8'h00) ? lt.data_done : expired_reg);
endmodule : master_latency_timer

// ===== rtl/bridge_config_header_mid.sv
// middle dwords of the bridge configuration header with forwarding decode
module bridge_config_header_mid
  import bridge_hdr_pkg::*;
(
  input wire logic clk,                          // primary clock
  input wire logic rst_n,                        // primary reset, low active
  input wire logic cfg_valid,                    // type 0 config data phase
  input wire logic [3:0] cfg_cmd,                // command code
  input wire logic [7:0] cfg_dword_addr,         // config byte address of dword
  input wire logic [3:0] upstream_cmd_byte_en_n, // byte enables, low active
  input wire logic [31:0] cfg_wdata,             // write data
  output logic [31:0] cfg_rdata,                 // read data
  output logic cfg_hit,                          // address falls in this block
  input wire logic pri_frame_start,              // we assert primary frame
  input wire logic pri_master_busy,              // we own primary bus as master
  input wire logic pri_gnt_removed,              // primary grant deasserted
  input wire logic pri_mwi_cycle,                // current cycle is write-invalidate
  input wire logic pri_data_done,                // first data phase completed
  output logic pri_timer_expired,                // latency timer expired
  output logic pri_release_bus,                  // give up the primary bus
  output logic [7:0] line_words,                 // effective cache line size
  output logic [7:0] latency_count,              // programmed latency count
  input wire logic pri_type1_valid,              // type 1 cycle seen on primary
  input wire logic [7:0] pri_type1_bus,          // its bus number
  output fwd_type pri_type1_action,              // how to forward it
  input wire logic sec_type1_valid,              // type 1 cycle seen on secondary
  input wire logic [7:0] sec_type1_bus,          // its bus number
  output logic sec_to_special,                   // convert to special cycle upstream
  output logic sec_pass_up,                      // pass upstream unaltered
  output logic [7:0] upstream_bus,               // upstream bus number
  output logic [7:0] downstream_bus,             // downstream bus number
  output logic [7:0] highest_bus                 // highest bus behind
);
  logic [7:0] cache_line_size_reg;
  logic [7:0] latency_reg;
  logic [7:0] upstream_bus_reg;
  logic [7:0] downstream_bus_reg;
  logic [7:0] highest_bus_reg;
  logic [31:0] rdata_next;
  logic [31:0] cfg_rdata_reg;
  logic [7:0] line_words_reg;
  logic [7:0] line_words_next;
  fwd_type pri_action_reg;
  fwd_type pri_action_next;
  logic sec_special_reg;
  logic sec_pass_reg;
  logic [3:0] lane_we;
  logic wr;
  latency_if lt ();

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  assign cfg_hit = (cfg_dword_addr == class_dword_offset) ||
    (cfg_dword_addr == cache_dword_offset) || (cfg_dword_addr == bus_dword_offset);
  assign wr = cfg_valid && (cfg_cmd == cmd_cfg_write);
  assign lane_we = {4{wr}} & ~upstream_cmd_byte_en_n;

  // ------------------------------------------------------------
  // writable fields
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cache_line_size_reg <= cache_line_reset;
      latency_reg <= latency_reset;
    end else if (cfg_dword_addr == cache_dword_offset) begin
      if (lane_we[0]) begin
        cache_line_size_reg <= cfg_wdata[cache_line_lsb +: 8];
      end
      if (lane_we[1]) begin
        latency_reg <= cfg_wdata[latency_lsb +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upstream_bus_reg <= bus_number_reset;
      downstream_bus_reg <= bus_number_reset;
      highest_bus_reg <= bus_number_reset;
    end else if (cfg_dword_addr == bus_dword_offset) begin
      if (lane_we[0]) begin
        upstream_bus_reg <= cfg_wdata[upstream_bus_lsb +: 8];
      end
      if (lane_we[1]) begin
        downstream_bus_reg <= cfg_wdata[downstream_bus_lsb +: 8];
      end
      if (lane_we[2]) begin
        highest_bus_reg <= cfg_wdata[highest_bus_lsb +: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (cfg_dword_addr)
      class_dword_offset: begin
        rdata_next[base_class_lsb +: 8] = base_class_value;
      end
      cache_dword_offset: begin
        rdata_next[cache_line_lsb +: 8] = cache_line_size_reg;
        rdata_next[latency_lsb +: 8] = latency_reg;
        rdata_next[header_type_lsb +: 8] = header_type_value;
      end
      bus_dword_offset: begin
        rdata_next[upstream_bus_lsb +: 8] = upstream_bus_reg;
        rdata_next[downstream_bus_lsb +: 8] = downstream_bus_reg;
        rdata_next[highest_bus_lsb +: 8] = highest_bus_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_rdata_reg <= 32'h0000_0000;
    end else if (cfg_valid && cfg_cmd == cmd_cfg_read) begin
      cfg_rdata_reg <= rdata_next;
    end
  end
  assign cfg_rdata = cfg_rdata_reg;

  // ------------------------------------------------------------
  // effective cache line size
  // ------------------------------------------------------------
  always_comb begin
    line_words_next = max_line_words;
    if (cache_line_size_reg <= max_line_words &&
        (cache_line_size_reg & (cache_line_size_reg - 8'h01)) == 8'h00 &&
        cache_line_size_reg != 8'h00) begin
      line_words_next = cache_line_size_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_words_reg <= max_line_words;
    end else begin
      line_words_reg <= line_words_next;
    end
  end
  assign line_words = line_words_reg;
  assign latency_count = latency_reg;

  // ------------------------------------------------------------
  // bus number decode for configuration forwarding
  // ------------------------------------------------------------
  always_comb begin
    pri_action_next = fwd_none;
    if (pri_type1_valid) begin
      if (pri_type1_bus == downstream_bus_reg) begin
        pri_action_next = fwd_type0;
      end else if (pri_type1_bus > downstream_bus_reg && pri_type1_bus <= highest_bus_reg) begin
        pri_action_next = fwd_type1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pri_action_reg <= fwd_none;
    end else begin
      pri_action_reg <= pri_action_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_special_reg <= 1'b0;
      sec_pass_reg <= 1'b0;
    end else begin
      sec_special_reg <= sec_type1_valid && (sec_type1_bus == upstream_bus_reg);
      sec_pass_reg <= sec_type1_valid && (sec_type1_bus != upstream_bus_reg) &&
        (sec_type1_bus < downstream_bus_reg || sec_type1_bus > highest_bus_reg);
    end
  end
  assign pri_type1_action = pri_action_reg;
  assign sec_to_special = sec_special_reg;
  assign sec_pass_up = sec_pass_reg;
  assign upstream_bus = upstream_bus_reg;
  assign downstream_bus = downstream_bus_reg;
  assign highest_bus = highest_bus_reg;

  // ------------------------------------------------------------
  // primary latency timer
  // ------------------------------------------------------------
  assign lt.count = latency_reg;
  assign lt.frame_start = pri_frame_start;
  assign lt.master_busy = pri_master_busy;
  assign lt.gnt_removed = pri_gnt_removed;
  assign lt.mwi_cycle = pri_mwi_cycle;
  assign lt.data_done = pri_data_done;
  assign pri_timer_expired = lt.expired;
  assign pri_release_bus = lt.release_bus;

  master_latency_timer timer_u (
    .clk(clk),
    .rst_n(rst_n),
    .lt(lt)
  );
endmodule : bridge_config_header_mid

// ===== tb/hdr_asserts.sv
// port-level checks for the middle bridge configuration header
module hdr_asserts
  import bridge_hdr_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, low active
  input wire logic cfg_valid, // access strobe
  input wire logic [3:0] cfg_cmd, // command
  input wire logic [7:0] cfg_dword_addr, // dword address
  input wire logic [3:0] upstream_cmd_byte_en_n, // lanes, low active
  input wire logic [31:0] cfg_wdata, // write data
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic cfg_hit, // address hit
  input wire logic pri_master_busy, // master on primary
  input wire logic pri_gnt_removed, // grant gone
  input wire logic pri_mwi_cycle, // write-invalidate
  input wire logic pri_data_done, // first data done
  input wire logic pri_release_bus, // release request
  input wire logic [7:0] line_words, // effective line
  input wire logic [7:0] latency_count, // latency value
  input wire logic pri_type1_valid, // primary request
  input wire logic [7:0] pri_type1_bus, // its bus
  input wire fwd_type pri_type1_action, // decision
  input wire logic sec_type1_valid, // secondary request
  input wire logic [7:0] sec_type1_bus, // its bus
  input wire logic sec_to_special, // to special cycle
  input wire logic [7:0] upstream_bus, // upstream number
  input wire logic [7:0] downstream_bus, // downstream number
  input wire logic [7:0] highest_bus // highest behind
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire rd = cfg_valid && cfg_cmd == cmd_cfg_read;
  wire wr = cfg_valid && cfg_cmd == cmd_cfg_write;
  class_const_a: assert property (rd && cfg_dword_addr == class_dword_offset
    |=> cfg_rdata[31:24] == base_class_value) else $error("class byte wrong");
  header_const_a: assert property (rd && cfg_dword_addr == cache_dword_offset
    |=> cfg_rdata[23:16] == header_type_value) else $error("header byte wrong");
  line_shape_a: assert property ($onehot(line_words) && line_words <= max_line_words)
    else $error("line size not power of two");
  lane_write_a: assert property (wr && cfg_dword_addr == bus_dword_offset
    && !upstream_cmd_byte_en_n[1] |=> downstream_bus == $past(cfg_wdata[15:8]))
    else $error("lane write lost");
  lane_keep_a: assert property (wr && upstream_cmd_byte_en_n[1] |=> $stable(downstream_bus))
    else $error("disabled lane changed");
  latency_write_a: assert property (wr && cfg_dword_addr == cache_dword_offset
    && !upstream_cmd_byte_en_n[1] |=> latency_count == $past(cfg_wdata[15:8]))
    else $error("latency write lost");
  fwd_type1_a: assert property (pri_type1_valid && pri_type1_bus > downstream_bus
    && pri_type1_bus <= highest_bus |=> pri_type1_action == fwd_type1)
    else $error("type 1 not forwarded");
  fwd_type0_a: assert property (pri_type1_valid && pri_type1_bus == downstream_bus
    |=> pri_type1_action == fwd_type0) else $error("type 0 not converted");
  special_up_a: assert property (sec_type1_valid && sec_type1_bus == upstream_bus
    |=> sec_to_special) else $error("special cycle missed");
  zero_release_a: assert property (latency_count == 8'h00 && pri_master_busy
    && pri_gnt_removed && !pri_mwi_cycle && pri_data_done |-> pri_release_bus)
    else $error("bus not released");
  unmapped_zero_a: assert property (rd && !cfg_hit |=> cfg_rdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (wr && cfg_dword_addr == bus_dword_offset);
  cover property (pri_type1_action == fwd_type1);
  cover property (pri_release_bus);
endmodule : hdr_asserts
bind bridge_config_header_mid hdr_asserts u_chk (.*);

// ===== tb/cfg_host.sv
// configuration host model driving type 0 accesses
module cfg_host (
  input wire logic clk, // clock
  output logic cfg_valid, // access strobe
  output logic [3:0] cfg_cmd, // command
  output logic [7:0] cfg_dword_addr, // dword address
  output logic [3:0] upstream_cmd_byte_en_n, // lanes, low active
  output logic [31:0] cfg_wdata, // write data
  input wire logic [31:0] cfg_rdata, // read data
  input wire logic cfg_hit // address hit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit_seen;
  initial begin
    hit_seen = 1'b0;
    cfg_valid = 1'b0;
    cfg_cmd = 4'h0;
    cfg_dword_addr = 8'h00;
    upstream_cmd_byte_en_n = 4'hf;
    cfg_wdata = 32'h0;
  end
  // one access; released command, address and data lines show the inverse so stale data never matches
  task automatic acc(input logic [3:0] c, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_cmd = c;
    cfg_dword_addr = a;
    upstream_cmd_byte_en_n = b;
    cfg_wdata = d;
    @(negedge clk);
    q = cfg_rdata;
    hit_seen = cfg_hit;
    cfg_valid = 1'b0;
    cfg_cmd = ~c;
    cfg_dword_addr = ~a;
    cfg_wdata = ~d;
  endtask : acc
endmodule : cfg_host

// ===== tb/tb.sv
// self-checking bench for the middle bridge configuration header
module tb import bridge_hdr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cfg_valid, cfg_hit, pri_frame_start, pri_master_busy, pri_gnt_removed;
  logic pri_mwi_cycle, pri_data_done, pri_timer_expired, pri_release_bus, pri_type1_valid;
  logic sec_type1_valid, sec_to_special, sec_pass_up;
  logic [3:0] cfg_cmd, upstream_cmd_byte_en_n;
  logic [7:0] cfg_dword_addr, line_words, latency_count, pri_type1_bus, sec_type1_bus;
  logic [7:0] upstream_bus, downstream_bus, highest_bus;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  fwd_type pri_type1_action;
  int miscompares, n_compared;
  bridge_config_header_mid DUT (.*);
  cfg_host h (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [3:0] b, logic [31:0] d);
    h.acc(cmd_cfg_write, a, b, d, q);
  endtask : wr
  task automatic rd(logic [7:0] a);
    h.acc(cmd_cfg_read, a, 4'h0, 32'h0, q);
  endtask : rd
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(class_dword_offset);
    chk("class", q & 32'hff000000, 32'h06000000);
    rd(cache_dword_offset);
    chk("dword0c", q & 32'h00ffffff, 32'h00010000);
    rd(bus_dword_offset);
    chk("dword18", q & 32'h00ffffff, 32'h0);
  endtask : t_reset
  task automatic t_lanes;
    wr(bus_dword_offset, 4'b1100, 32'h00aa0201);
    wr(bus_dword_offset, 4'b1011, 32'hff05ffff);
    rd(bus_dword_offset);
    chk("dword18", q & 32'h00ffffff, 32'h00050201);
    chk("bus outputs", {8'h0, highest_bus, downstream_bus, upstream_bus}, 32'h00050201);
    chk("hit", {31'h0, h.hit_seen}, 32'h1);
    wr(class_dword_offset, 4'b0000, 32'hffffffff);
    wr(cache_dword_offset, 4'b0000, 32'hffffffff);
    rd(class_dword_offset);
    chk("class", q & 32'hff000000, 32'h06000000);
    rd(cache_dword_offset);
    chk("dword0c", q & 32'h00ffffff, 32'h0001ffff);
    rd(8'h10);
    chk("unmapped", q, 32'h0);
    chk("miss", {31'h0, h.hit_seen}, 32'h0);
  endtask : t_lanes
  task automatic t_line;
    logic [7:0] v[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h10, 8'h20, 8'hff};
    logic [7:0] e[9] = '{8'h10, 8'h01, 8'h02, 8'h10, 8'h04, 8'h08, 8'h10, 8'h10, 8'h10};
    foreach (v[i]) begin
      wr(cache_dword_offset, 4'b1110, {24'h0, v[i]});
      repeat (2) @(negedge clk);
      chk("line_words", {24'h0, line_words}, {24'h0, e[i]});
    end
  endtask : t_line
  task automatic t_timer;
    wr(cache_dword_offset, 4'b1101, 32'h00000400);
    chk("latency", {24'h0, latency_count}, 32'h4);
    pri_master_busy = 1'b1;
    pri_frame_start = 1'b1;
    @(negedge clk);
    pri_frame_start = 1'b0;
    repeat (2) @(negedge clk);
    chk("expired early", {31'h0, pri_timer_expired}, 32'h0);
    @(negedge clk);
    chk("expired", {31'h0, pri_timer_expired}, 32'h1);
    wr(cache_dword_offset, 4'b1101, 32'h0);
    pri_gnt_removed = 1'b1;
    pri_data_done = 1'b1;
    #1;
    chk("release", {31'h0, pri_release_bus}, 32'h1);
    @(negedge clk);
    pri_mwi_cycle = 1'b1;
    #1;
    chk("release mwi", {31'h0, pri_release_bus}, 32'h0);
    @(negedge clk);
    {pri_master_busy, pri_gnt_removed, pri_data_done, pri_mwi_cycle} = 4'h0;
  endtask : t_timer
  task automatic t_fwd;
    logic [7:0] pb[5] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h01};
    logic [1:0] pe[5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
    logic [7:0] sb[5] = '{8'h01, 8'h07, 8'h03, 8'h00, 8'h06};
    logic [1:0] se[5] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h1};
    foreach (pb[i]) begin
      @(negedge clk);
      {pri_type1_valid, pri_type1_bus, sec_type1_valid, sec_type1_bus} = {1'b1, pb[i], 1'b1, sb[i]};
      @(negedge clk);
      {pri_type1_valid, sec_type1_valid, pri_type1_bus, sec_type1_bus} = {2'b0, ~pb[i], ~sb[i]};
      chk("pri action", {30'h0, pri_type1_action}, {30'h0, pe[i]});
      chk("sec action", {30'h0, sec_to_special, sec_pass_up}, {30'h0, se[i]});
    end
  endtask : t_fwd
  initial begin
    {rst_n, pri_frame_start, pri_master_busy, pri_gnt_removed, pri_mwi_cycle} = 5'h0;
    {pri_data_done, pri_type1_valid, sec_type1_valid, pri_type1_bus, sec_type1_bus} = 19'h0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_lanes();
    t_line();
    t_timer();
    t_fwd();
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    tally_and_finish();
  end
  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb
